// ==== sac_cmp_model.sv ====
// comparator stand-in: analog level against the trial code
`timescale 1ns/1ps
module sac_cmp_model (
	input wire logic [11:0] dac_code_in,
	input wire logic [11:0] level_in,
	output logic comp_out
);
	// keep the trial bit while the trial does not exceed the level
	assign comp_out = (dac_code_in <= level_in);
endmodule

// ==== sac_defs.svh ====
// constants for the converter control block
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_W 12
`define SAC_TICK_DIV_LAST 8'h09
`define SAC_ACQ_LAST 4'h1
`define SAC_BIT_LAST 4'h0
`define SAC_MSB_IDX 4'hB
`define SAC_FULL_LAST_IDX 4'h0
`define SAC_SHORT_LAST_IDX 4'h4
`define SAC_SHORT_TAIL 4'h8
`define SAC_OE_NONE 12'h000
`define SAC_OE_WORD 12'hFFF
`define SAC_OE_HIGH 12'hFF0
`define SAC_OE_LOW 12'h0FF
`define SAC_ZERO_NIB 4'h0
`define SAC_ZERO_WORD 12'h000
`define SAC_ONE_HOT 12'h001
`endif

// ==== sac_pkg.sv ====
// types shared by the converter control block
package sac_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} sac_state_t;
	typedef enum logic [1:0] {OE_NONE, OE_WORD, OE_HIGH, OE_LOW} sac_oe_t;
endpackage

// ==== sac_sar_engine.sv ====
// successive approximation sequencer on an internal clock
`timescale 1ns/1ps
`include "sac_defs.svh"
module sac_sar_engine (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic start_in,
	input wire logic short_mode_in,
	input wire logic comparator_in,
	output logic busy_out,
	output logic hold_out,
	output logic [11:0] trial_out,
	output logic [11:0] result_out
);
	sac_pkg::sac_state_t state_r;
	logic [7:0] div_r;
	logic [3:0] cnt_r;
	logic [3:0] bit_r;
	logic tick;
	logic [3:0] last_idx;
	assign tick = (div_r == `SAC_TICK_DIV_LAST);
	assign last_idx = short_mode_in ? `SAC_SHORT_LAST_IDX : `SAC_FULL_LAST_IDX;
	// internal clock, restarted at each start taken while idle for a fixed aperture
	always_ff @(posedge clk_sys_in) begin
		// a start refused while busy must not shift the running tick grid
		if (!reset_n_in || tick ||
			(start_in && state_r == sac_pkg::ST_IDLE)) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state_r <= sac_pkg::ST_IDLE;
			cnt_r <= 4'h0;
			bit_r <= `SAC_MSB_IDX;
			busy_out <= 1'b0;
			hold_out <= 1'b0;
		end else begin
			case (state_r)
				sac_pkg::ST_IDLE: begin
					// starts only taken while idle
					if (start_in) begin
						state_r <= sac_pkg::ST_ACQ;
						cnt_r <= 4'h0;
						bit_r <= `SAC_MSB_IDX;
						busy_out <= 1'b1;
					end
				end
				sac_pkg::ST_ACQ: begin
					if (tick) begin
						if (cnt_r == `SAC_ACQ_LAST) begin
							state_r <= sac_pkg::ST_CONV;
							cnt_r <= 4'h0;
							hold_out <= 1'b1;
						end else begin
							cnt_r <= cnt_r + 4'h1;
						end
					end
				end
				sac_pkg::ST_CONV: begin
					if (tick) begin
						if (cnt_r == `SAC_BIT_LAST) begin
							cnt_r <= 4'h0;
							// a late switch to short mode ends at bit 4, or at the current bit if already below it
							if (bit_r <= last_idx) begin
								state_r <= sac_pkg::ST_IDLE;
								busy_out <= 1'b0;
								hold_out <= 1'b0;
							end else begin
								bit_r <= bit_r - 4'h1;
							end
						end else begin
							cnt_r <= cnt_r + 4'h1;
						end
					end
				end
				default: begin
					state_r <= sac_pkg::ST_IDLE;
					busy_out <= 1'b0;
					hold_out <= 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			result_out <= `SAC_ZERO_WORD;
		end else if (state_r == sac_pkg::ST_IDLE && start_in) begin
			result_out <= `SAC_ZERO_WORD;
		end else if (state_r == sac_pkg::ST_CONV && tick &&
			cnt_r == `SAC_BIT_LAST) begin
			result_out[bit_r] <= comparator_in;
			// short conversion ends with 1000 in the low nibble
			if (bit_r <= last_idx && short_mode_in) begin
				result_out[3:0] <= `SAC_SHORT_TAIL;
			end
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			trial_out <= `SAC_ZERO_WORD;
		end else if (state_r == sac_pkg::ST_CONV) begin
			trial_out <= result_out | (`SAC_ONE_HOT << bit_r);
		end else begin
			trial_out <= `SAC_ZERO_WORD;
		end
	end
endmodule

// ==== sac_start_detect.sv ====
// start transition detector and byte select capture
`timescale 1ns/1ps
`include "sac_defs.svh"
module sac_start_detect (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic chip_en_in,
	input wire logic chip_sel_n_in,
	input wire logic read_conv_in,
	input wire logic byte_address_select_in,
	output logic start_out,
	output logic short_mode_out
);
	logic cond;
	logic cond_r;
	// all three must be in start state; last arrival makes the edge
	assign cond = chip_en_in & ~chip_sel_n_in & ~read_conv_in;
	// one compare of the combined level: same delay for every input
	assign start_out = cond & ~cond_r;
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			cond_r <= 1'b1;
		end else begin
			cond_r <= cond;
		end
	end
	// captured on every start edge, busy or not
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			short_mode_out <= 1'b0;
		end else if (start_out) begin
			short_mode_out <= byte_address_select_in;
		end
	end
endmodule

// ==== sac_top.sv ====
// converter control top: start, busy status and output buffer gating
`timescale 1ns/1ps
`include "sac_defs.svh"
module sac_top (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic chip_en_in,
	input wire logic chip_sel_n_in,
	input wire logic read_conv_in,
	input wire logic word_sel_in,
	input wire logic byte_address_select_in,
	input wire logic comparator_in,
	output logic conversion_busy_flag_out,
	output logic sample_hold_out,
	output logic [11:0] dac_code_out,
	output logic [11:0] data_out,
	output logic [11:0] data_oe_out
);
	logic start;
	logic short_mode;
	logic busy;
	logic [11:0] result;
	logic read_ok;
	sac_pkg::sac_oe_t want;
	sac_pkg::sac_oe_t mode_r;
	sac_pkg::sac_oe_t mode_nxt;

	sac_start_detect u_start (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.chip_en_in(chip_en_in),
		.chip_sel_n_in(chip_sel_n_in),
		.read_conv_in(read_conv_in),
		.byte_address_select_in(byte_address_select_in),
		.start_out(start),
		.short_mode_out(short_mode)
	);

	sac_sar_engine u_sar (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.start_in(start),
		.short_mode_in(short_mode),
		.comparator_in(comparator_in),
		.busy_out(busy),
		.hold_out(sample_hold_out),
		.trial_out(dac_code_out),
		.result_out(result)
	);

	assign conversion_busy_flag_out = busy;
	// live levels only; busy also blocks the buffers
	assign read_ok = read_conv_in & ~busy & chip_en_in & ~chip_sel_n_in;

	always_comb begin
		want = sac_pkg::OE_NONE;
		if (read_ok) begin
			if (word_sel_in) begin
				want = sac_pkg::OE_WORD;
			end else if (!byte_address_select_in) begin
				want = sac_pkg::OE_HIGH;
			end else begin
				want = sac_pkg::OE_LOW;
			end
		end
		mode_nxt = want;
		// one idle cycle between differing drive groups
		if (want != sac_pkg::OE_NONE && mode_r != sac_pkg::OE_NONE &&
			want != mode_r) begin
			mode_nxt = sac_pkg::OE_NONE;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			mode_r <= sac_pkg::OE_NONE;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			data_oe_out <= `SAC_OE_NONE;
			data_out <= `SAC_ZERO_WORD;
		end else begin
			case (mode_nxt)
				sac_pkg::OE_WORD: begin
					data_oe_out <= `SAC_OE_WORD;
					data_out <= result;
				end
				sac_pkg::OE_HIGH: begin
					data_oe_out <= `SAC_OE_HIGH;
					data_out <= {result[11:4], `SAC_ZERO_NIB};
				end
				sac_pkg::OE_LOW: begin
					// lines 7..4 forced low, low nibble right-justified on lines 3..0
					data_oe_out <= `SAC_OE_LOW;
					data_out <= {`SAC_ZERO_NIB, `SAC_ZERO_NIB, result[3:0]};
				end
				default: begin
					data_oe_out <= `SAC_OE_NONE;
					data_out <= `SAC_ZERO_WORD;
				end
			endcase
		end
	end
endmodule

// ==== sac_top_asserts.sv ====
// assertions on the converter control top ports
`timescale 1ns/1ps
module sac_top_asserts (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic chip_en_in,
	input wire logic chip_sel_n_in,
	input wire logic read_conv_in,
	input wire logic word_sel_in,
	input wire logic byte_address_select_in,
	input wire logic conversion_busy_flag_out,
	input wire logic sample_hold_out,
	input wire logic [11:0] data_out,
	input wire logic [11:0] data_oe_out
);
	logic [7:0] cnt_r;
	wire logic bsy = conversion_busy_flag_out;
	wire logic [11:0] oe = data_oe_out;
	wire logic go = chip_en_in & ~chip_sel_n_in & ~read_conv_in;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in || !bsy)
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_r + 8'h01;
	end
	sequence s_acq;
		!sample_hold_out [*8] ##[13:15] sample_hold_out;
	endsequence
	AST_START: assert property ($rose(go) && !bsy |=> bsy)
		else $error("no busy");
	AST_FLOAT: assert property (bsy |-> oe == 12'h000)
		else $error("oe while busy");
	AST_READ: assert property (oe != 12'h000 |-> $past(read_conv_in
		&& !bsy && chip_en_in && !chip_sel_n_in)) else $error("bad read");
	AST_WORD: assert property (oe == 12'hFFF |-> $past(word_sel_in))
		else $error("bad word");
	AST_MSB: assert property (oe == 12'hFF0 |-> data_out[3:0] == 4'h0
		&& $past(!word_sel_in && !byte_address_select_in)) else $error("msb");
	AST_LSB: assert property (oe == 12'h0FF |-> data_out[7:4] == 4'h0
		&& $past(!word_sel_in && byte_address_select_in)) else $error("lsb");
	AST_BBM: assert property (oe != 12'h000 && $past(oe) != 12'h000
		|-> oe == $past(oe)) else $error("overlap");
	AST_LEN: assert property ($fell(bsy)
		|-> cnt_r inside {[97:104], [137:144]}) else $error("length");
	AST_ACQ: assert property ($rose(bsy) |-> s_acq)
		else $error("acquire");
	AST_HOLD: assert property (sample_hold_out |-> bsy)
		else $error("hold idle");
endmodule
bind sac_top sac_top_asserts u_chk (.clk_sys_in, .reset_n_in, .chip_en_in,
	.chip_sel_n_in, .read_conv_in, .word_sel_in, .byte_address_select_in,
	.conversion_busy_flag_out, .sample_hold_out, .data_out, .data_oe_out);

// ==== testbench.sv ====
// self-checking bench for the converter control top
`timescale 1ns/1ps
module testbench;
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic ce = 1'b1, csn = 1'b0, rc = 1'b1, ws = 1'b1, bs = 1'b0;
	logic cmp, busy;
	logic [11:0] v = 12'hA5C, code, oe, dat, go, gd, gz;
	int fails = 0, checks_done = 0, n;
	always #5 clk_sys_in = ~clk_sys_in;
	sac_top u_dut (.clk_sys_in, .reset_n_in, .chip_en_in(ce),
		.chip_sel_n_in(csn), .read_conv_in(rc), .word_sel_in(ws),
		.byte_address_select_in(bs), .comparator_in(cmp),
		.conversion_busy_flag_out(busy), .sample_hold_out(),
		.dac_code_out(code), .data_out(dat), .data_oe_out(oe));
	sac_cmp_model u_cmp (.dac_code_in(code), .level_in(v), .comp_out(cmp));
	task stop_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk_sys_in);
		#1;
	endtask
	task start(input int t, input logic b);
		tick(1);
		bs = b;
		// the governing input stays off; the other two settle 60 ns ahead
		ce = (t != 1);
		csn = (t == 2);
		rc = (t == 0);
		tick(6);
		ce = 1'b1;
		csn = 1'b0;
		rc = 1'b0;
		tick(2);
	endtask
	task done;
		n = 0;
		while (busy === 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		chk("busy_end", 12'h000, {11'h000, busy});
	endtask
	task rd(input logic w, input logic b);
		ws = w;
		bs = b;
		rc = 1'b1;
		tick(1);
		gz = oe;
		tick(2);
		go = oe;
		gd = dat;
	endtask
	initial begin
		tick(5);
		reset_n_in = 1'b1;
		for (int t = 0; t < 3; t++) begin
			start(t, 1'b0);
			chk("busy", 12'h001, {11'h000, busy});
			done;
			rd(1'b1, 1'b0);
			chk("word", v, gd);
			chk("word_oe", 12'hFFF, go);
		end
		start(0, 1'b1);
		done;
		rd(1'b1, 1'b0);
		chk("short", {v[11:4], 4'h8}, gd);
		rd(1'b0, 1'b0);
		chk("msb_gap", 12'h000, gz);
		chk("msb_oe", 12'hFF0, go);
		chk("msb", {v[11:4], 4'h0}, gd);
		rd(1'b0, 1'b1);
		chk("lsb_gap", 12'h000, gz);
		chk("lsb_oe", 12'h0FF, go);
		chk("lsb", 12'h008, gd);
		v = 12'h3C7;
		start(0, 1'b0);
		rc = 1'b1;
		bs = 1'b1;
		tick(20);
		chk("oe_busy", 12'h000, oe);
		rc = 1'b0;
		tick(1);
		done;
		chk("no_restart", 12'h001, {11'h000, n < 90});
		rd(1'b1, 1'b0);
		chk("recapture", {v[11:4], 4'h8}, gd);
		ce = 1'b0;
		rc = 1'b0;
		tick(3);
		chk("ce_off", 12'h000, {11'h000, busy});
		ce = 1'b1;
		csn = 1'b1;
		rc = 1'b1;
		tick(3);
		chk("cs_off", 12'h000, oe);
		stop_test;
	end
	initial begin
		tick(5000);
		fails++;
		stop_test;
	end
endmodule
